/* File: gearbox_consts.svh */
// Constants for the input gearbox: widths, word lengths, reset values and the list of behaviours.
// Operation
// - Gear one or two serial streams into 8-bit words.
// - Modes: 7-bit video, 8-bit, or two 4-bit.
// - Split mode: first cell lands on bits 7..4.
// - Split mode: third cell lands on bits 3..0.
// - Core alignment request slips the word boundary.
// - Serial input taken after the input delay.
`ifndef GEARBOX_CONSTS_SVH
`define GEARBOX_CONSTS_SVH

// Parallel word width and FIFO depth.
`define WORD_W 8
`define FIFO_DEPTH 8
// Number of synchronised pin inputs: two edge-clock phases and two serial lines.
`define PIN_N 4
// Word lengths of the first cell's gearbox, one per mode.
`define LEN_VIDEO 4'h7
`define LEN_WIDE 4'h8
`define LEN_SPLIT 4'h4
// Count of the last bit of a third-cell half word.
`define HALF_LAST 3'h3
// Counter step values.
`define CNT_ONE 4'h1
`define HALF_ONE 3'h1
// Reset values.
`define CNT_RST 4'h0
`define HALF_RST 3'h0
`define WORD_RST 8'h00
`define HALF_WORD_RST 4'h0
`define PIN_RST 4'h0
// Bit positions of the pin vector.
`define PIN_A 0
`define PIN_C 1
`define PIN_EC_LO 2
`define PIN_EC_HI 3

`endif

/* File: gearbox_pkg.sv */
// Types shared by the input gearbox design.
`default_nettype none
package gearbox_pkg;
    // Gearing mode selected by core logic, one-hot.
    typedef enum logic [2:0] {
        MODE_VIDEO = 3'b001,
        MODE_WIDE = 3'b010,
        MODE_SPLIT = 3'b100
    } gear_mode_t;
endpackage : gearbox_pkg
`default_nettype wire

/* File: input_gearbox.sv */
// Input gearbox: pin synchronisers, serial-to-parallel gearing, output FIFO and registered output stage.
`timescale 1ns/1ps
`default_nettype none
`include "gearbox_consts.svh"

// Small synchronous FIFO of flip-flops with valid and ready on both sides.
module gear_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];   // Storage words.
    logic [AW-1:0] wr_q;       // Write index.
    logic [AW-1:0] rd_q;       // Read index.
    logic [AW:0] cnt_q;        // Words held.
    logic do_wr;
    logic do_rd;

    assign in_ready = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // Storage is written only, never reset, since the count guards every read.
    always_ff @(posedge clk) begin
        if (clk_en && do_wr) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Indices wrap at the depth so that any depth, not only a power of two, works.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : gear_fifo

// Top of the gearbox.
module input_gearbox (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire gearbox_pkg::gear_mode_t gear_mode,
    input wire logic delayed_serial_a,
    input wire logic delayed_serial_c,
    input wire logic [1:0] fast_edge_clock,
    input wire logic word_align_request,
    output logic [`WORD_W-1:0] word_q,
    output logic word_valid_q,
    input wire logic word_ready,
    output logic overrun_q
);
    logic [`PIN_N-1:0] pin_vec;   // Pins gathered for synchronisation.
    logic [`PIN_N-1:0] s1_q;      // First stage, read only by the second.
    logic [`PIN_N-1:0] s2_q;      // Second stage.
    logic [`PIN_N-1:0] s3_q;      // Third stage.
    logic [`PIN_N-1:0] filt_q;    // Accepted pin levels.
    logic [`PIN_N-1:0] filt_d;
    logic cap;                    // A bit-clock edge was seen this cycle.
    logic cap_go;                 // The edge is taken, FIFO has room.
    logic bit_a;
    logic bit_c;
    logic [3:0] len_a;            // Word length of the first cell.
    logic [3:0] cnt_a_q;          // Bits gathered by the first cell.
    logic [2:0] cnt_c_q;          // Bits gathered by the third cell.
    logic [7:0] sh_a_q;           // First-cell shift register.
    logic [7:0] sh_a_d;
    logic [3:0] sh_c_q;           // Third-cell shift register.
    logic [3:0] sh_c_d;
    logic align_pend_q;           // An alignment slip waits for the next bit.
    logic a_done;
    logic c_done;
    logic push;
    logic [`WORD_W-1:0] word_d;   // Word offered to the FIFO.
    logic [`WORD_W-1:0] hold_q;   // Last word pushed, keeps the idle half in split mode.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`WORD_W-1:0] fifo_out_data;
    logic pop;

    assign pin_vec = {fast_edge_clock, delayed_serial_c, delayed_serial_a};

    // Three-stage synchronisers for every pin; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= `PIN_RST;
            s2_q <= `PIN_RST;
            s3_q <= `PIN_RST;
        end else if (clk_en) begin
            s1_q <= pin_vec;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A pin level is accepted only when the second and third stages agree, filtering a metastable sample.
    always_comb begin
        filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end

    // Accepted levels, used for edge detection on the edge-clock phases.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_q <= `PIN_RST;
        end else if (clk_en) begin
            filt_q <= filt_d;
        end
    end

    // A rising edge on either phase of the edge clock samples one serial bit.
    assign cap = |(filt_d[`PIN_EC_HI:`PIN_EC_LO] & ~filt_q[`PIN_EC_HI:`PIN_EC_LO]);
    // A full FIFO stalls capture; the missed bits are reported as overrun.
    assign cap_go = cap && fifo_in_ready;
    assign bit_a = filt_d[`PIN_A];
    assign bit_c = filt_d[`PIN_C];

    // The word length follows the gearing mode.
    always_comb begin
        unique case (gear_mode)
            gearbox_pkg::MODE_VIDEO: len_a = `LEN_VIDEO;
            gearbox_pkg::MODE_WIDE: len_a = `LEN_WIDE;
            gearbox_pkg::MODE_SPLIT: len_a = `LEN_SPLIT;
            default: len_a = `LEN_WIDE;
        endcase
    end

    assign sh_a_d = {sh_a_q[6:0], bit_a};
    assign sh_c_d = {sh_c_q[2:0], bit_c};
    // A word ends at its last bit; a pending slip holds the counters for one bit instead.
    // Comparing with >= recovers cleanly if the mode shrinks mid-word.
    assign a_done = cap_go && !align_pend_q && (cnt_a_q >= len_a - `CNT_ONE);
    assign c_done = cap_go && !align_pend_q && (gear_mode == gearbox_pkg::MODE_SPLIT)
        && (cnt_c_q == `HALF_LAST);
    assign push = a_done || c_done;

    // Assemble the word for each mode; in split mode each half is independent.
    always_comb begin
        unique case (gear_mode)
            gearbox_pkg::MODE_VIDEO: word_d = {1'b0, sh_a_d[6:0]};
            gearbox_pkg::MODE_SPLIT: begin
                word_d[7:4] = a_done ? sh_a_d[3:0] : hold_q[7:4];
                word_d[3:0] = c_done ? sh_c_d : hold_q[3:0];
            end
            default: word_d = sh_a_d;
        endcase
    end

    // Shift registers take every taken bit, even during a slip; bits are dropped only while the FIFO is full.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_a_q <= `WORD_RST;
            sh_c_q <= `HALF_WORD_RST;
        end else if (clk_en && cap_go) begin
            sh_a_q <= sh_a_d;
            sh_c_q <= sh_c_d;
        end
    end

    // Bit counters mark where the word boundary falls.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_a_q <= `CNT_RST;
            cnt_c_q <= `HALF_RST;
        end else if (clk_en && cap_go && !align_pend_q) begin
            cnt_a_q <= a_done ? `CNT_RST : cnt_a_q + `CNT_ONE;
            if (gear_mode == gearbox_pkg::MODE_SPLIT) begin
                cnt_c_q <= c_done ? `HALF_RST : cnt_c_q + `HALF_ONE;
            end
        end
    end

    // Alignment request from the core; a new request wins over the clear by a taken bit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            align_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (word_align_request) begin
                align_pend_q <= 1'b1;
            end else if (cap_go) begin
                align_pend_q <= 1'b0;
            end
        end
    end

    // Last pushed word, so the idle half in split mode repeats its previous value.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_q <= `WORD_RST;
        end else if (clk_en && push) begin
            hold_q <= word_d;
        end
    end

    // Sticky overrun, set when an edge arrives with the FIFO full; only reset clears it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overrun_q <= 1'b0;
        end else if (clk_en && cap && !fifo_in_ready) begin
            overrun_q <= 1'b1;
        end
    end

    gear_fifo #(
        .W(`WORD_W),
        .D(`FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(word_d),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    assign pop = fifo_out_valid && (!word_valid_q || word_ready);

    // Registered output stage on the system clock; a word stands until the core takes it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_q <= `WORD_RST;
            word_valid_q <= 1'b0;
        end else if (clk_en) begin
            if (pop) begin
                word_q <= fifo_out_data;
                word_valid_q <= 1'b1;
            end else if (word_ready) begin
                word_valid_q <= 1'b0;
            end
        end
    end

    // Checks on the gearing behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    video_top_bit_a: assert property (push && gear_mode == gearbox_pkg::MODE_VIDEO |-> !word_d[7])
        else $error("video word has bit 7 set");
    wide_word_len_a: assert property (a_done && gear_mode == gearbox_pkg::MODE_WIDE |-> cnt_a_q == 4'h7)
        else $error("eight-bit word pushed at the wrong bit count");
    split_hi_keep_a: assert property (c_done && !a_done && gear_mode == gearbox_pkg::MODE_SPLIT
        |-> word_d[7:4] == hold_q[7:4])
        else $error("third-cell word disturbed the upper half");
    split_lo_keep_a: assert property (a_done && !c_done && gear_mode == gearbox_pkg::MODE_SPLIT
        |-> word_d[3:0] == hold_q[3:0])
        else $error("first-cell word disturbed the lower half");
    align_slip_a: assert property (clk_en && cap_go && align_pend_q && !word_align_request
        |=> $stable(cnt_a_q) && !align_pend_q)
        else $error("alignment slip did not hold the counter");
    serial_shift_a: assert property (clk_en && cap_go |=> sh_a_q[0] == $past(filt_d[`PIN_A]))
        else $error("shifted bit is not the delayed serial input");
    // The default disable would switch this check off at the very edge it starts on, so it opts out.
    reset_clear_a: assert property (@(posedge clk) disable iff (1'b0) sys_rst |=> cnt_a_q == `CNT_RST && !word_valid_q)
        else $error("reset did not clear the gearbox");
    word_hold_a: assert property (word_valid_q && !word_ready |=> word_valid_q && $stable(word_q))
        else $error("output word changed before it was taken");
    full_stall_a: assert property (clk_en && cap && !fifo_in_ready |=> overrun_q && $stable(cnt_a_q))
        else $error("edge with a full FIFO was not refused and flagged");

    video_word_c: cover property (push && gear_mode == gearbox_pkg::MODE_VIDEO);
    split_both_c: cover property (a_done && c_done && gear_mode == gearbox_pkg::MODE_SPLIT);
    align_wide_c: cover property (align_pend_q && cap_go ##[1:200] a_done);
    overrun_c: cover property (cap && !fifo_in_ready);
endmodule : input_gearbox
`default_nettype wire

/* File: serial_source.sv */
// Behavioural serial source: two serial lines and the two-phase edge clock in front of the gearbox.
`timescale 1ns/1ps
`default_nettype none
module serial_source (
    input wire logic clk,
    output logic [1:0] fast_edge_clock,
    output logic serial_a,
    output logic serial_c
);
    // Phase that carries the next bit; the phases alternate as in double data rate.
    logic phase = 1'b0;

    // Lines start low so that reset does not see a stray edge.
    initial begin
        fast_edge_clock = 2'b00;
        serial_a = 1'b0;
        serial_c = 1'b0;
    end

    // Sends n bits on each line, highest first, every level set four cycles before its edge and held eight cycles after it.
    task automatic send(input int n, input logic [7:0] a, input logic [7:0] c);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            serial_a <= a[i];
            serial_c <= c[i];
            repeat (4) @(posedge clk);
            fast_edge_clock[phase] <= 1'b1;
            repeat (4) @(posedge clk);
            fast_edge_clock[phase] <= 1'b0;
            phase = ~phase;
            repeat (3) @(posedge clk);
        end
        // The lines are undriven after a frame; the inverse keeps a stale bit from passing for a fresh one.
        @(posedge clk);
        serial_a <= ~serial_a;
        serial_c <= ~serial_c;
    endtask : send
endmodule : serial_source
`default_nettype wire

/* File: input_gearbox_test.sv */
// Self-checking testbench for the input gearbox.
`timescale 1ns/1ps
`default_nettype none
module input_gearbox_test;
    logic clk;
    logic sys_rst;
    logic clk_en;
    gearbox_pkg::gear_mode_t gear_mode;
    logic word_align_request;
    logic word_ready;
    logic [1:0] fast_edge_clock;
    logic delayed_serial_a;
    logic delayed_serial_c;
    logic [7:0] word_q;
    logic word_valid_q;
    logic overrun_q;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    input_gearbox i_input_gearbox (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .gear_mode(gear_mode),
        .delayed_serial_a(delayed_serial_a), .delayed_serial_c(delayed_serial_c),
        .fast_edge_clock(fast_edge_clock), .word_align_request(word_align_request), .word_q(word_q),
        .word_valid_q(word_valid_q), .word_ready(word_ready), .overrun_q(overrun_q));

    serial_source i_serial_source (.clk(clk), .fast_edge_clock(fast_edge_clock), .serial_a(delayed_serial_a),
        .serial_c(delayed_serial_c));

    // System clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counts a comparison and reports it at once if it differs.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits a bounded time for a word, looking at falling edges where outputs have settled.
    task automatic expect_word(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (word_valid_q !== 1'b1 && n < 400);
        // A word that never arrives counts as a mismatch of its own.
        check({7'h00, word_valid_q}, 8'h01);
        check(word_q, exp);
    endtask : expect_word

    // Eight bits arrive highest first and form one word.
    task automatic wide_word;
        gear_mode <= gearbox_pkg::MODE_WIDE;
        fork
            i_serial_source.send(8, 8'hA5, 8'h00);
            expect_word(8'hA5);
        join
    endtask : wide_word

    // Seven bits fill the low bits; the top bit must stay clear.
    task automatic video_word;
        gear_mode <= gearbox_pkg::MODE_VIDEO;
        fork
            i_serial_source.send(7, 8'h5A, 8'h00);
            expect_word(8'h5A);
        join
    endtask : video_word

    // Both halves finish together, so a single word carries both.
    task automatic split_word;
        gear_mode <= gearbox_pkg::MODE_SPLIT;
        fork
            i_serial_source.send(4, 8'h0C, 8'h03);
            expect_word(8'hC3);
        join
    endtask : split_word

    // A slip absorbs one leading bit; without it the word would read 9E.
    task automatic aligned_word;
        gear_mode <= gearbox_pkg::MODE_WIDE;
        word_align_request <= 1'b1;
        @(posedge clk);
        word_align_request <= 1'b0;
        fork
            begin
                i_serial_source.send(1, 8'h01, 8'h00);
                i_serial_source.send(8, 8'h3C, 8'h00);
            end
            expect_word(8'h3C);
        join
    endtask : aligned_word

    // Core stalls; output stage and FIFO take nine words, the tenth is lost and flagged.
    task automatic overrun_drain;
        word_ready <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            i_serial_source.send(8, 8'h10 + i[7:0], 8'h00);
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
        check({7'h00, overrun_q}, 8'h01);
        @(posedge clk);
        word_ready <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            expect_word(8'h10 + i[7:0]);
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check({6'h00, overrun_q, word_valid_q}, 8'h00);
    endtask : overrun_drain

    // Two bits taken in eight-bit mode put the first cell two bits ahead, so each half then ends on its own.
    task automatic split_apart;
        @(posedge clk);
        gear_mode <= gearbox_pkg::MODE_WIDE;
        i_serial_source.send(2, 8'h02, 8'h01);
        gear_mode <= gearbox_pkg::MODE_SPLIT;
        fork
            i_serial_source.send(4, 8'h05, 8'h0A);
            begin
                expect_word(8'h90);
                expect_word(8'h9A);
            end
        join
    endtask : split_apart

    // Prints the verdict and ends the run.
    task automatic test_done;
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // The run needs about 1500 cycles; the ceiling leaves ample room.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            test_done;
        end
    end

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        gear_mode = gearbox_pkg::MODE_WIDE;
        word_align_request = 1'b0;
        word_ready = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wide_word;
        video_word;
        split_word;
        aligned_word;
        overrun_drain;
        split_apart;
        test_done;
    end
endmodule : input_gearbox_test
`default_nettype wire
